//--- wdt_pkg.sv
// Package for the I/O port watchdog timer: port address, field widths,
// interval limits and the derived one-second tick count.
// Assumes a 50 MHz core clock.
package wdt_pkg;
  localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
  localparam int DATA_W = 8;
  localparam int SEC_W = 6;
  localparam logic [SEC_W-1:0] INTERVAL_MIN = 6'h01;
  localparam logic [SEC_W-1:0] INTERVAL_MAX = 6'h3F;
  localparam logic [SEC_W-1:0] INTERVAL_ZERO = 6'h00;
  localparam int CLK_HZ = 50000000;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICK_W = 26;
  localparam logic [TICK_W-1:0] TICK_ZERO = 26'h0000000;
  localparam logic [TICK_W-1:0] TICK_ONE = 26'h0000001;
  localparam logic [DATA_W-1:0] READ_FILL = 8'h00;
  localparam int ACT_PULSE_CYCLES = 16;
  localparam logic [4:0] ACT_ZERO = 5'h00;
  localparam logic [4:0] ACT_ONE = 5'h01;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_FIRE = 2'b10
  } wdt_state_e;
endpackage

//--- wdt_tick_gen.sv
// One-second tick generator for the watchdog countdown.
// Assumes a synchronous active-low reset on the core clock.
module wdt_tick_gen #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  output logic tick
);
  logic [wdt_pkg::TICK_W-1:0] cnt_r;
  logic [wdt_pkg::TICK_W-1:0] cnt_nxt;
  logic [wdt_pkg::TICK_W-1:0] last;

  assign last = wdt_pkg::TICK_W'(TICK_CYCLES - 1);

  // Restart realigns the second so a refresh always gets full seconds.
  always_comb begin
    cnt_nxt = cnt_r + wdt_pkg::TICK_ONE;
    if (restart || cnt_r == last) begin
      cnt_nxt = wdt_pkg::TICK_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= wdt_pkg::TICK_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = (cnt_r == last) && !restart;
endmodule

//--- io_port_watchdog_timer.sv
// Watchdog timer reached through one byte-wide host I/O port.
// Assumes host strobes are one-cycle pulses on CORE_CLK with the address
// and data valid in the same cycle.
module io_port_watchdog_timer #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_HIT,
  input wire logic ACTION_IRQ,
  output logic CPU_RESET,
  output logic WDT_IRQ,
  output logic WDT_ARMED
);
  // ==========================================================
  // Port decode
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic tick;

  assign hit = (IO_ADDR == wdt_pkg::WDT_PORT_ADDR);
  assign wr_hit = hit && IO_WR;
  assign rd_hit = hit && IO_RD && !IO_WR;
  assign IO_HIT = hit && (IO_WR || IO_RD);

  // ==========================================================
  // Action select synchroniser
  // The action strap is a board pin with no relation to CORE_CLK, so it
  // passes three flops and only a value seen twice in a row is taken.
  logic [2:0] act_sync_r;
  logic [2:0] act_sync_nxt;
  logic irq_pin_r;
  logic irq_pin_nxt;

  always_comb begin
    act_sync_nxt = {act_sync_r[1:0], ACTION_IRQ};
    irq_pin_nxt = irq_pin_r;
    if (act_sync_r[1] == act_sync_r[2]) begin
      irq_pin_nxt = act_sync_r[2];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      act_sync_r <= 3'h0;
      irq_pin_r <= 1'h0;
    end else begin
      act_sync_r <= act_sync_nxt;
      irq_pin_r <= irq_pin_nxt;
    end
  end

  // ==========================================================
  // Countdown state
  wdt_pkg::wdt_state_e state_r;
  wdt_pkg::wdt_state_e state_nxt;
  logic [wdt_pkg::SEC_W-1:0] secs_r;
  logic [wdt_pkg::SEC_W-1:0] secs_nxt;
  logic [4:0] act_r;
  logic [4:0] act_nxt;
  logic irq_sel_r;
  logic irq_sel_nxt;
  logic [wdt_pkg::SEC_W-1:0] wcode;

  // Codes above 3F fold into six bits; code 00 is treated as disarm since
  // no zero-second interval exists.
  assign wcode = IO_WDATA[wdt_pkg::SEC_W-1:0];

  wdt_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .restart(wr_hit),
    .tick(tick)
  );

  always_comb begin
    state_nxt = state_r;
    secs_nxt = secs_r;
    act_nxt = act_r;
    irq_sel_nxt = irq_sel_r;
    unique case (state_r)
      wdt_pkg::ST_IDLE: begin
        act_nxt = wdt_pkg::ACT_ZERO;
      end
      wdt_pkg::ST_ARMED: begin
        if (tick) begin
          secs_nxt = secs_r - wdt_pkg::INTERVAL_MIN;
          if (secs_r == wdt_pkg::INTERVAL_MIN) begin
            state_nxt = wdt_pkg::ST_FIRE;
            act_nxt = 5'(wdt_pkg::ACT_PULSE_CYCLES - 1);
            irq_sel_nxt = irq_pin_r;
          end
        end
      end
      wdt_pkg::ST_FIRE: begin
        act_nxt = act_r - wdt_pkg::ACT_ONE;
        if (act_r == wdt_pkg::ACT_ZERO) begin
          state_nxt = wdt_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = wdt_pkg::ST_IDLE;
      end
    endcase
    // A write takes priority over a pending expiry so a late refresh wins.
    if (wr_hit) begin
      secs_nxt = wcode;
      act_nxt = wdt_pkg::ACT_ZERO;
      if (wcode == wdt_pkg::INTERVAL_ZERO) begin
        state_nxt = wdt_pkg::ST_IDLE;
      end else begin
        state_nxt = wdt_pkg::ST_ARMED;
      end
    end else if (rd_hit) begin
      state_nxt = wdt_pkg::ST_IDLE;
      act_nxt = wdt_pkg::ACT_ZERO;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state_r <= wdt_pkg::ST_IDLE;
      secs_r <= wdt_pkg::INTERVAL_ZERO;
      act_r <= wdt_pkg::ACT_ZERO;
      irq_sel_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      secs_r <= secs_nxt;
      act_r <= act_nxt;
      irq_sel_r <= irq_sel_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // The action and status pins are registered from the next state so a
  // CPU reset line never sees decode glitches between state bits.
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic cpu_rst_r;
  logic cpu_rst_nxt;
  logic irq_r;
  logic irq_nxt;
  logic armed_r;
  logic armed_nxt;

  always_comb begin
    rdata_nxt = wdt_pkg::READ_FILL;
    if (rd_hit) begin
      rdata_nxt = {2'b00, secs_r};
    end
    cpu_rst_nxt = (state_nxt == wdt_pkg::ST_FIRE) && !irq_sel_nxt;
    irq_nxt = (state_nxt == wdt_pkg::ST_FIRE) && irq_sel_nxt;
    armed_nxt = (state_nxt == wdt_pkg::ST_ARMED);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rdata_r <= wdt_pkg::READ_FILL;
      cpu_rst_r <= 1'b0;
      irq_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      cpu_rst_r <= cpu_rst_nxt;
      irq_r <= irq_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign IO_RDATA = rdata_r;
  assign CPU_RESET = cpu_rst_r;
  assign WDT_IRQ = irq_r;
  assign WDT_ARMED = armed_r;

  // ==========================================================
  // Checks
  write_arms_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    wr_hit && wcode != wdt_pkg::INTERVAL_ZERO |=>
    WDT_ARMED && secs_r == $past(wcode))
    else $error("write did not arm with interval");
  code_range_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    WDT_ARMED |-> secs_r >= wdt_pkg::INTERVAL_MIN)
    else $error("armed with zero interval");
  refresh_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    wr_hit && wcode != wdt_pkg::INTERVAL_ZERO |=> !CPU_RESET && !WDT_IRQ)
    else $error("refresh did not restart");
  read_off_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    rd_hit |=> !WDT_ARMED && !CPU_RESET && !WDT_IRQ)
    else $error("read did not disable");
  read_data_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    rd_hit |=> IO_RDATA == {2'b00, $past(secs_r)})
    else $error("read data is not the remaining time");
  expire_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    WDT_ARMED && tick && secs_r == wdt_pkg::INTERVAL_MIN && !IO_WR && !IO_RD
    |=> CPU_RESET != WDT_IRQ)
    else $error("expiry gave no action");
  one_action_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !(CPU_RESET && WDT_IRQ))
    else $error("both actions at once");
  fire_source_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    ($rose(CPU_RESET) || $rose(WDT_IRQ)) |-> $past(WDT_ARMED))
    else $error("action raised while not armed");
  pulse_end_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    state_r == wdt_pkg::ST_FIRE && act_r == wdt_pkg::ACT_ZERO && !wr_hit
    |=> !CPU_RESET && !WDT_IRQ)
    else $error("action pulse did not end");
  only_tick_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    WDT_ARMED && !tick && !IO_HIT |=> $stable(secs_r))
    else $error("countdown moved without tick");
  reset_idle_a: assert property (
    @(posedge CORE_CLK)
    !RESETN |=> !WDT_ARMED && !CPU_RESET && !WDT_IRQ)
    else $error("not disarmed after reset");
  cov_refresh_c: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
    WDT_ARMED && wr_hit);
  cov_reset_c: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
    $rose(CPU_RESET));
  cov_irq_c: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
    $rose(WDT_IRQ));
  cov_disable_c: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
    WDT_ARMED && rd_hit);
endmodule

//--- wdt_host_model.sv
// Host processor model that issues single-byte I/O writes and reads.
// Assumes the watchdog samples strobes on the rising clock edge.
module wdt_host_model (
  input wire logic clk,
  output logic [15:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // Each rewrite of a code with nonzero low six bits from the host is a refresh of the countdown.
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // A released bus is driven inverted so stale values never match.
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

//--- tb_io_port_watchdog_timer.sv
// Self-checking bench for the I/O port watchdog timer.
// Assumes a shortened second of 10 clock cycles.
module tb_io_port_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 10;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic ACTION_IRQ = 1'b0;
  logic [15:0] IO_ADDR;
  logic IO_WR, IO_RD, IO_HIT, CPU_RESET, WDT_IRQ, WDT_ARMED;
  logic [7:0] IO_WDATA, IO_RDATA;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  wdt_host_model u_wdt_host_model (.clk(CORE_CLK), .addr(IO_ADDR),
    .wr(IO_WR), .rd(IO_RD), .wdata(IO_WDATA), .rdata(IO_RDATA));
  io_port_watchdog_timer #(.TICK_CYCLES(TICKS)) u_io_port_watchdog_timer (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
    .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .IO_HIT(IO_HIT), .ACTION_IRQ(ACTION_IRQ), .CPU_RESET(CPU_RESET),
    .WDT_IRQ(WDT_IRQ), .WDT_ARMED(WDT_ARMED));
  // ==========================================================
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_wdt_host_model.io_write(a, d);
  endtask
  // Looks at IO_HIT in the middle of the strobe cycle of one write.
  task automatic wr_hit_chk(input logic [15:0] a, input logic [7:0] d,
                            input logic exp);
    fork
      wr(a, d);
      begin
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        chk(IO_HIT === exp, "port hit wrong");
      end
    join
  endtask
  // Measures the delay from the last write to the expiry pulse and its width.
  task automatic fire_after(input int secs, input logic irq);
    int n;
    int m;
    n = 0;
    m = 0;
    while ((CPU_RESET | WDT_IRQ) !== 1'b1 && n < 800) begin
      @(negedge CORE_CLK);
      n++;
    end
    chk(n >= secs * TICKS && n <= secs * TICKS + 2, "expiry time wrong");
    chk(WDT_IRQ === irq && CPU_RESET === !irq, "expiry action wrong");
    while ((CPU_RESET | WDT_IRQ) === 1'b1 && m < 40) begin
      @(negedge CORE_CLK);
      m++;
    end
    chk(m == 16 && WDT_ARMED === 1'b0, "expiry pulse wrong");
  endtask
  task automatic give_verdict;
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_expire(input logic [7:0] code, input int secs,
                          input logic irq);
    @(posedge CORE_CLK) ACTION_IRQ <= irq;
    wr(wdt_pkg::WDT_PORT_ADDR, code);
    @(negedge CORE_CLK);
    chk(WDT_ARMED === 1'b1, "not armed by write");
    fire_after(secs, irq);
  endtask
  task automatic t_refresh;
    wr(wdt_pkg::WDT_PORT_ADDR, 8'h03);
    repeat (25) @(negedge CORE_CLK);
    wr(wdt_pkg::WDT_PORT_ADDR, 8'h41);
    fire_after(1, 1'b0);
  endtask
  task automatic t_read;
    logic [7:0] d;
    bit seen;
    seen = 0;
    wr(wdt_pkg::WDT_PORT_ADDR, 8'h02);
    repeat (5) @(negedge CORE_CLK);
    u_wdt_host_model.io_read(wdt_pkg::WDT_PORT_ADDR, d);
    chk(d === 8'h02 && WDT_ARMED === 1'b0, "read did not disarm");
    repeat (40) begin
      @(negedge CORE_CLK);
      if ((CPU_RESET | WDT_IRQ) !== 1'b0) seen = 1;
    end
    chk(!seen, "expiry after disarm");
  endtask
  task automatic t_reset_mid;
    bit seen;
    seen = 0;
    wr(wdt_pkg::WDT_PORT_ADDR, 8'h01);
    repeat (5) @(posedge CORE_CLK);
    RESETN <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    @(negedge CORE_CLK);
    chk(WDT_ARMED === 1'b0, "reset left armed");
    repeat (30) begin
      @(negedge CORE_CLK);
      if ((CPU_RESET | WDT_IRQ) !== 1'b0) seen = 1;
    end
    chk(!seen, "expiry after reset");
  endtask
  task automatic t_other;
    wr_hit_chk(16'h0444, 8'h01, 1'b0);
    @(negedge CORE_CLK);
    chk(WDT_ARMED === 1'b0, "other address armed");
    wr_hit_chk(wdt_pkg::WDT_PORT_ADDR, 8'h05, 1'b1);
    @(negedge CORE_CLK);
    chk(WDT_ARMED === 1'b1, "port write did not arm");
    wr(wdt_pkg::WDT_PORT_ADDR, 8'h00);
    @(negedge CORE_CLK);
    chk(WDT_ARMED === 1'b0, "code zero armed");
  endtask
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    @(negedge CORE_CLK);
    chk((WDT_ARMED | CPU_RESET | WDT_IRQ) === 1'b0, "not idle");
    t_expire(8'h01, 1, 1'b0);
    t_expire(8'h02, 2, 1'b1);
    t_expire(8'hFF, 63, 1'b0);
    t_refresh();
    t_read();
    t_reset_mid();
    t_other();
    give_verdict();
  end
endmodule
